// ### inc/sms_consts.svh
// Purpose: Named offsets, field positions and reset values of the serial port
// Assumes: Register index times four is the APB byte address
// Notes:   Character length field value zero stands for eight bits
`ifndef SMS_CONSTS_SVH
`define SMS_CONSTS_SVH

// Register indices
`define SMS_IDX_DATA   12'hF60
`define SMS_IDX_CTRL   12'hF61
`define SMS_IDX_STAT   12'hF62
`define SMS_IDX_MODE   12'hF63
`define SMS_IDX_BRH    12'hF66
`define SMS_IDX_BRL    12'hF67

// Control register fields
`define SMS_C_INTERRUPT_ENABLE     7
`define SMS_C_STR      6
`define SMS_C_TIMER_INTERRUPT_ENABLE     5
`define SMS_C_PHASE    4
`define SMS_C_POL      3
`define SMS_C_WOR      2
`define SMS_C_MASTER_MODE_ENABLE     1
`define SMS_C_EN       0

// Status register fields
`define SMS_S_IRQ      7
`define SMS_S_OVR      6
`define SMS_S_COL      5
`define SMS_S_ABT      4
`define SMS_S_BUSY     1
`define SMS_S_SEL      0

// Mode register fields
`define SMS_M_LEN_HI   4
`define SMS_M_LEN_LO   2
`define SMS_M_SELECT_DIRECTION     1
`define SMS_M_SSV      0

// Reset values and counts
`define SMS_CTRL_RST   8'h00
`define SMS_MODE_RST   8'h00
`define SMS_BR_RST     8'h00
`define SMS_DATA_RST   8'h00
`define SMS_LEN_FULL   4'h8
`define SMS_LEN_ZERO   3'h0
`define SMS_BRG_WRAP   17'h10000
`define SMS_BRG_LAST   17'h00001

`endif

// ### inc/sms_pkg.sv
// Purpose: Types shared by the serial port modules
// Assumes: Nothing beyond the constants header
// Notes:   States are one-hot
package sms_pkg;

  typedef enum logic [1:0] {
    SMS_IDLE = 2'b01,
    SMS_BUSY = 2'b10
  } sms_state_e;

endpackage : sms_pkg

// ### core/sms_sync.sv
// Purpose: Two-flop synchroniser for the port pins
// Assumes: Inputs are asynchronous to core_clk
// Notes:   First stage feeds only the second
`timescale 1ns/1ps
`default_nettype none
module sms_sync #(
  parameter int W = 4
) (
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] async_bits,
  output logic      [W-1:0] sync_bits
);
  logic [W-1:0] meta_r;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r    <= '1;
      sync_bits <= '1;
    end else begin
      meta_r    <= async_bits;
      sync_bits <= meta_r;
    end
  end
endmodule // sms_sync
`default_nettype wire

// ### core/sms_baud_gen.sv
// Purpose: Baud divider that also serves as a plain interval timer
// Assumes: Reload zero means 65536 cycles
// Notes:   One tick every reload cycles while running
`timescale 1ns/1ps
`default_nettype none
`include "sms_consts.svh"
module sms_baud_gen (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        run,
  input  wire logic        restart,
  input  wire logic [15:0] reload,
  output logic             tick
);
  logic [16:0] cnt_r;
  logic [16:0] load;

  assign load = (reload == 16'h0000) ? `SMS_BRG_WRAP : {1'b0, reload};

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= `SMS_BRG_WRAP;
      tick  <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (!run || restart) begin
        cnt_r <= load;
      end else if (cnt_r == `SMS_BRG_LAST) begin
        tick  <= 1'b1;
        cnt_r <= load;
      end else begin
        cnt_r <= cnt_r - `SMS_BRG_LAST;
      end
    end
  end
endmodule // sms_baud_gen
`default_nettype wire

// ### core/sms_port.sv
// Purpose: Four-wire serial port, master or slave, with APB registers
// Assumes: core_clk 100 MHz; pins pass a two-flop synchroniser
// Notes:   Data register is the single shift register
//
// How it works
// R01: Slave-out drives only when slave and selected
// R02: Port disabled floats both data lines
// R03: Characters move most significant bit first
// R04: Master drives divided clock; slave takes it in
// R05: Slave ignores clock while select is high
// R06: Far master keeps clock period eight cycles
// R07: One bit per clock; shift, sample opposite edges
// R08: Far master holds select low per character
// R09: Multimaster select is input, low means collision
// R10: Four clock modes; polarity sets idle level
// R11: Same modes both ends; data half-cycle early
// R12: Slave when enabled, not master, select input
// R13: Slave ignores timer enable, select value, divider
// R14: Slave sends current register from first edge
// R15: Write while busy keeps data, sets overrun
// R16: Enabled master with select low flags collision
// R17: Select rising mid-character aborts, sets pending
// R18: After abort next select sends bit seven
// R19: Interrupt on every completed character
// R20: Write one clears pending; needed before next
// R21: Force bit raises pending interrupt request
// R22: Disabled timer timeout interrupts without pending
// R23: Bit rate is clock over twice reload
// R24: Master write starts; slave write preloads
// R25: Short characters leave top, arrive bottom
//
// The implementer's own choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "sms_consts.svh"
module sms_port
  import sms_pkg::*;
#(
  parameter int AW = 16
) (
  input  wire logic          core_clk,
  input  wire logic          rst_n,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [AW-1:0] paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  input  wire logic          sck_pin,
  output logic               sck_drv,
  output logic               sck_oe,
  input  wire logic          mosi_pin,
  output logic               mosi_drv,
  output logic               mosi_oe,
  input  wire logic          miso_pin,
  output logic               miso_drv,
  output logic               miso_oe,
  input  wire logic          sel_n_pin,
  output logic               sel_n_drv,
  output logic               sel_n_oe,
  output logic               irq_req
);

  function automatic logic reg_hit(input logic [AW-1:0] a,
                                   input logic [11:0] idx);
    reg_hit = (a == AW'({idx, 2'b00}));
  endfunction

  function automatic logic [3:0] char_len(input logic [2:0] f);
    char_len = (f == `SMS_LEN_ZERO) ? `SMS_LEN_FULL : {1'b0, f};
  endfunction

  logic [7:0]  ctrl_r;
  logic [7:0]  mode_r;
  logic [7:0]  brh_r;
  logic [7:0]  brl_r;
  logic [7:0]  shreg_r;
  sms_state_e  state_r;
  logic [3:0]  cnt_r;
  logic        half_r;
  logic        rx_bit_r;
  logic        out_r;
  logic        sck_r;
  logic        sck_prev_r;
  logic        ss_prev_r;
  logic        ovr_r;
  logic        col_r;
  logic        abt_r;
  logic        pend_r;
  logic        sck_s;
  logic        mosi_s;
  logic        miso_s;
  logic        ss_s;
  logic        tick;

  logic port_en;
  logic pol;
  logic pha;
  logic sel_dir;
  logic master_mode;
  logic slave_mode;
  logic busy;
  logic acc;
  logic wr_data;
  logic wr_ctrl;
  logic wr_stat;
  logic wr_mode;
  logic wr_brh;
  logic wr_brl;
  logic start_m;
  logic m_lead;
  logic m_trail;
  logic s_lead;
  logic s_trail;
  logic lead_ev;
  logic trail_ev;
  logic done_ev;
  logic abort_ev;
  logic col_ev;
  logic ovr_ev;
  logic pend_set;
  logic timer_ev;
  logic din;
  logic mapped;
  logic [3:0] len;

  sms_sync #(
    .W (4)
  ) u_sync (
    .core_clk   (core_clk),
    .rst_n      (rst_n),
    .async_bits ({sck_pin, mosi_pin, miso_pin, sel_n_pin}),
    .sync_bits  ({sck_s, mosi_s, miso_s, ss_s})
  );

  // Divider runs only for a master transfer or the disabled-port timer
  sms_baud_gen u_baud (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .run      ((master_mode && busy) ||
               (!port_en && ctrl_r[`SMS_C_TIMER_INTERRUPT_ENABLE])),  // see R13
    .restart  (start_m),
    .reload   ({brh_r, brl_r}),                     // see R23
    .tick     (tick)
  );

  assign port_en     = ctrl_r[`SMS_C_EN];
  assign pol         = ctrl_r[`SMS_C_POL];
  assign pha         = ctrl_r[`SMS_C_PHASE];
  assign sel_dir     = mode_r[`SMS_M_SELECT_DIRECTION];
  assign master_mode = port_en && ctrl_r[`SMS_C_MASTER_MODE_ENABLE];
  assign slave_mode  = port_en && !ctrl_r[`SMS_C_MASTER_MODE_ENABLE] && !sel_dir; // see R12
  assign busy        = (state_r == SMS_BUSY);
  assign len         = char_len(mode_r[`SMS_M_LEN_HI:`SMS_M_LEN_LO]);

  // Register access
  assign acc     = psel && penable && pready;
  assign wr_data = acc && pwrite && reg_hit(paddr, `SMS_IDX_DATA);
  assign wr_ctrl = acc && pwrite && reg_hit(paddr, `SMS_IDX_CTRL);
  assign wr_stat = acc && pwrite && reg_hit(paddr, `SMS_IDX_STAT);
  assign wr_mode = acc && pwrite && reg_hit(paddr, `SMS_IDX_MODE);
  assign wr_brh  = acc && pwrite && reg_hit(paddr, `SMS_IDX_BRH);
  assign wr_brl  = acc && pwrite && reg_hit(paddr, `SMS_IDX_BRL);
  assign mapped  = reg_hit(paddr, `SMS_IDX_DATA) ||
                   reg_hit(paddr, `SMS_IDX_CTRL) ||
                   reg_hit(paddr, `SMS_IDX_STAT) ||
                   reg_hit(paddr, `SMS_IDX_MODE) ||
                   reg_hit(paddr, `SMS_IDX_BRH)  ||
                   reg_hit(paddr, `SMS_IDX_BRL);

  // Edge events; master receive needs a reload of four or more
  assign start_m  = wr_data && master_mode && !busy;            // see R24
  assign m_lead   = master_mode && busy && tick && !half_r;     // see R04
  assign m_trail  = master_mode && busy && tick && half_r;
  assign s_lead   = slave_mode && !ss_s &&
                    (sck_prev_r == pol) && (sck_s != pol);      // see R05
  assign s_trail  = slave_mode && !ss_s && busy &&
                    (sck_prev_r != pol) && (sck_s == pol);
  assign lead_ev  = m_lead || s_lead;
  assign trail_ev = m_trail || s_trail;
  assign done_ev  = trail_ev && ((cnt_r + 4'h1) == len);        // see R07
  assign abort_ev = slave_mode && busy && ss_s;                 // see R17
  assign col_ev   = master_mode && !sel_dir && !ss_s;           // see R16 R09
  assign ovr_ev   = wr_data && busy;                            // see R15
  assign pend_set = done_ev || abort_ev ||
                    (wr_ctrl && pwdata[`SMS_C_STR]);            // see R21
  assign timer_ev = tick && !port_en && ctrl_r[`SMS_C_TIMER_INTERRUPT_ENABLE];    // see R22
  assign din      = master_mode ? miso_s : mosi_s;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sck_prev_r <= 1'b1;
      ss_prev_r  <= 1'b1;
    end else begin
      sck_prev_r <= sck_s;
      ss_prev_r  <= ss_s;
    end
  end

  // Control registers; force bit drops with the pending clear
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= `SMS_CTRL_RST;
      mode_r <= `SMS_MODE_RST;
      brh_r  <= `SMS_BR_RST;
      brl_r  <= `SMS_BR_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_r <= pwdata[7:0];
      end else if (wr_stat && pwdata[`SMS_S_IRQ]) begin
        ctrl_r[`SMS_C_STR] <= 1'b0;
      end
      if (wr_mode) begin
        mode_r <= pwdata[7:0];
      end
      if (wr_brh) begin
        brh_r <= pwdata[7:0];
      end
      if (wr_brl) begin
        brl_r <= pwdata[7:0];
      end
    end
  end

  // Transfer sequencing
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= SMS_IDLE;
      cnt_r   <= 4'h0;
    end else if (!port_en || abort_ev) begin
      state_r <= SMS_IDLE;
      cnt_r   <= 4'h0;
    end else begin
      case (state_r)
        SMS_IDLE: begin
          if (start_m || s_lead) begin                          // see R14
            state_r <= SMS_BUSY;
            cnt_r   <= 4'h0;
          end
        end
        SMS_BUSY: begin
          if (done_ev) begin                                    // see R19
            state_r <= SMS_IDLE;
            cnt_r   <= 4'h0;
          end else if (trail_ev) begin
            cnt_r <= cnt_r + 4'h1;
          end
        end
        default: begin
          state_r <= SMS_IDLE;
          cnt_r   <= 4'h0;
        end
      endcase
    end
  end

  // Master clock, idle at the polarity level
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sck_r  <= 1'b0;
      half_r <= 1'b0;
    end else if (!(master_mode && busy) || start_m) begin
      sck_r  <= pol;                                            // see R10
      half_r <= 1'b0;
    end else if (tick) begin
      sck_r  <= half_r ? pol : !pol;                            // see R23
      half_r <= !half_r;
    end
  end

  // Shift register: out on transmit edge, in on receive edge
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      shreg_r  <= `SMS_DATA_RST;
      rx_bit_r <= 1'b0;
      out_r    <= 1'b0;
    end else if (wr_data && !busy) begin
      shreg_r <= pwdata[7:0];                                   // see R24
      out_r   <= pwdata[7];                                     // see R03
    end else if (slave_mode && ss_prev_r && !ss_s) begin
      out_r <= shreg_r[7];                                      // see R18
    end else if (lead_ev) begin
      if (pha) begin
        out_r <= shreg_r[7];                                    // see R11
      end else begin
        rx_bit_r <= din;                                        // see R07
      end
    end else if (trail_ev) begin
      shreg_r <= {shreg_r[6:0], pha ? din : rx_bit_r};          // see R25
      if (!pha) begin
        out_r <= shreg_r[6];                                    // see R03
      end
    end
  end

  // Error flags; a new event wins over a clear
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ovr_r <= 1'b0;
    end else if (ovr_ev) begin
      ovr_r <= 1'b1;                                            // see R15
    end else if (wr_stat && pwdata[`SMS_S_OVR]) begin
      ovr_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      col_r <= 1'b0;
    end else if (col_ev) begin
      col_r <= 1'b1;                                            // see R16
    end else if (wr_stat && pwdata[`SMS_S_COL]) begin
      col_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      abt_r <= 1'b0;
    end else if (abort_ev) begin
      abt_r <= 1'b1;                                            // see R17
    end else if (wr_stat && pwdata[`SMS_S_ABT]) begin
      abt_r <= 1'b0;                                            // see R18
    end
  end

  // Pending flag and request pulse
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_r  <= 1'b0;
      irq_req <= 1'b0;
    end else begin
      if (pend_set) begin
        pend_r <= 1'b1;
      end else if (wr_stat && pwdata[`SMS_S_IRQ]) begin
        pend_r <= 1'b0;                                         // see R20
      end
      irq_req <= (ctrl_r[`SMS_C_INTERRUPT_ENABLE] && pend_set && !pend_r) ||
                 timer_ev;                                      // see R19 R22
    end
  end

  // Pin drivers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sck_drv   <= 1'b0;
      sck_oe    <= 1'b0;
      mosi_drv  <= 1'b0;
      mosi_oe   <= 1'b0;
      miso_drv  <= 1'b0;
      miso_oe   <= 1'b0;
      sel_n_drv <= 1'b1;
      sel_n_oe  <= 1'b0;
    end else begin
      sck_drv   <= sck_r;
      sck_oe    <= master_mode;                                 // see R04
      mosi_drv  <= out_r;
      mosi_oe   <= master_mode &&
                   (!ctrl_r[`SMS_C_WOR] || !out_r);             // see R02
      miso_drv  <= out_r;
      miso_oe   <= slave_mode && !ss_s &&
                   (!ctrl_r[`SMS_C_WOR] || !out_r);             // see R01
      sel_n_drv <= mode_r[`SMS_M_SSV];
      sel_n_oe  <= master_mode && sel_dir;                      // see R13
    end
  end

  // APB answer: one access cycle, no wait state
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      if (psel && !penable && !pwrite) begin
        if (reg_hit(paddr, `SMS_IDX_DATA)) begin
          prdata <= {24'h00_0000, shreg_r};
        end else if (reg_hit(paddr, `SMS_IDX_CTRL)) begin
          prdata <= {24'h00_0000, ctrl_r};
        end else if (reg_hit(paddr, `SMS_IDX_STAT)) begin
          prdata <= {24'h00_0000, pend_r, ovr_r, col_r, abt_r,
                     2'b00, busy, ss_s};
        end else if (reg_hit(paddr, `SMS_IDX_MODE)) begin
          prdata <= {24'h00_0000, mode_r};
        end else if (reg_hit(paddr, `SMS_IDX_BRH)) begin
          prdata <= {24'h00_0000, brh_r};
        end else if (reg_hit(paddr, `SMS_IDX_BRL)) begin
          prdata <= {24'h00_0000, brl_r};
        end else begin
          prdata <= 32'h0000_0000;
        end
      end
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  AST_MISO_FLOAT: assert property ( // see R01
    miso_oe |-> $past(slave_mode) && !$past(ss_s))
    else $error("slave-out driven while not a selected slave");
  AST_DISABLED_HIZ: assert property ( // see R02
    !$past(port_en) |-> !mosi_oe && !miso_oe && !sck_oe)
    else $error("data line driven while port disabled");
  AST_MSB_FIRST: assert property ( // see R03
    start_m |-> ##2 mosi_drv == $past(pwdata[7], 2))
    else $error("master did not present bit seven first");
  AST_SCK_IDLE: assert property ( // see R10
    !busy && master_mode && $stable(pol) [*3] |-> sck_drv == pol)
    else $error("master clock not at idle level");
  AST_OVERRUN: assert property ( // see R15
    ovr_ev && !trail_ev |=> ovr_r && $stable(shreg_r))
    else $error("busy write altered data or missed overrun");
  AST_COLLISION: assert property ( // see R16
    col_ev |=> col_r)
    else $error("collision flag not set");
  AST_ABORT: assert property ( // see R17
    abort_ev |=> abt_r && pend_r && !busy)
    else $error("slave abort not flagged");
  AST_FORCE: assert property ( // see R21
    wr_ctrl && pwdata[`SMS_C_STR] && ctrl_r[`SMS_C_INTERRUPT_ENABLE] && !pend_r
    |=> pend_r && irq_req)
    else $error("forced interrupt not raised");
  AST_TIMER: assert property ( // see R22
    timer_ev && !pend_set |=> irq_req && (pend_r == $past(pend_r)))
    else $error("timer timeout handled wrongly");
  AST_PEND_CLEAR: assert property ( // see R20
    (wr_stat && pwdata[`SMS_S_IRQ] && !pend_set) ##1 (!pend_set && !timer_ev)
    |-> !pend_r ##1 !irq_req)
    else $error("pending flag not cleared");

  COV_MASTER_DONE: cover property (master_mode && done_ev);
  COV_SLAVE_DONE:  cover property (slave_mode && done_ev);
  COV_SLAVE_ABORT: cover property (abort_ev);
  COV_TIMER:       cover property (timer_ev);

endmodule // sms_port
`default_nettype wire

// ### dv/sms_far_slave.sv
// Purpose: Far slave model facing the port in master tests
// Assumes: Clock, data and select are resolved wires
// Notes:   A released data line shows the inverse of its last bit
`timescale 1ns/1ps
`default_nettype none
module sms_far_slave (
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic       sel_n,
  input  wire logic       cpol,
  input  wire logic       cpha,
  input  wire logic [7:0] tx_byte,
  output logic            miso,
  output logic      [7:0] rx_byte
);
  logic [7:0] sh;
  logic       bit_q;

  assign miso = sel_n ? ~bit_q : bit_q;

  initial begin
    sh = 8'h00;
    bit_q = 1'b0;
    rx_byte = 8'h00;
  end

  // Phase zero shows the top bit as soon as select falls
  always @(negedge sel_n) begin
    sh = tx_byte;
    if (!cpha) begin
      bit_q = sh[7];
      sh = sh << 1;
    end
  end

  // Sample on one edge, shift on the other
  always @(sck) begin
    if (!sel_n) begin
      if ((sck != cpol) ^ cpha)
        rx_byte = {rx_byte[6:0], mosi};
      else begin
        bit_q = sh[7];
        sh = sh << 1;
      end
    end
  end
endmodule // sms_far_slave
`default_nettype wire

// ### dv/sms_port_tb.sv
// Purpose: Self-checking bench for the serial port
// Assumes: Far slave model in master tests; bench is master otherwise
// Notes:   Seeded random data, lengths and dividers; clock modes stepped by loop index
`timescale 1ns/1ps
`default_nettype none
`include "sms_consts.svh"
module sms_port_tb;
  logic        core_clk, rst_n, psel, penable, pwrite, rerr;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, sck_drv, sck_oe, mosi_drv, mosi_oe;
  logic        miso_drv, miso_oe, sel_n_drv, sel_n_oe, irq_req;
  logic        tb_sck, tb_mosi, tb_sel_n, m_cpol, m_cpha, mdl_miso;
  logic [7:0]  m_tx, m_rx;
  int          err_total, checked, irq_n, cyc, seed;
  time         t_prev, t_last;
  logic [11:0] rix [5] = '{`SMS_IDX_DATA, `SMS_IDX_CTRL, `SMS_IDX_MODE,
                           `SMS_IDX_BRH, `SMS_IDX_BRL};
  wire logic   sck   = sck_oe ? sck_drv : tb_sck;
  wire logic   mosi  = mosi_oe ? mosi_drv : tb_mosi;
  wire logic   miso  = miso_oe ? miso_drv : mdl_miso;
  wire logic   sel_n = sel_n_oe ? sel_n_drv : tb_sel_n;

  sms_port #(.AW(16)) sms_port_inst (
    .core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sck_pin(sck), .sck_drv(sck_drv),
    .sck_oe(sck_oe), .mosi_pin(mosi), .mosi_drv(mosi_drv),
    .mosi_oe(mosi_oe), .miso_pin(miso), .miso_drv(miso_drv),
    .miso_oe(miso_oe), .sel_n_pin(sel_n), .sel_n_drv(sel_n_drv),
    .sel_n_oe(sel_n_oe), .irq_req(irq_req));

  sms_far_slave sms_far_slave_inst (
    .sck(sck), .mosi(mosi), .sel_n(sel_n), .cpol(m_cpol), .cpha(m_cpha),
    .tx_byte(m_tx), .miso(mdl_miso), .rx_byte(m_rx));

  initial core_clk = 1'b0;
  always #5 core_clk = ~core_clk;

  always @(sck) begin
    t_prev = t_last;
    t_last = $time;
  end

  always @(posedge core_clk) begin
    cyc++;
    if (irq_req === 1'b1)
      irq_n++;
    if (cyc == 20000) begin
      err_total++;
      wrap_up();
    end
  end

  function automatic logic [2:0] len_f(int n);
    return (n == 8) ? 3'h0 : 3'(n);
  endfunction

  function automatic logic [7:0] top_f(logic [7:0] b, int n);
    return b >> (8 - n);
  endfunction

  function automatic logic [7:0] lo_f(int n);
    return 8'hFF >> (8 - n);
  endfunction

  task automatic wrap_up();
    $display("Checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] ix,
                     input logic [7:0] wd, output logic [31:0] r);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, ix, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n == 50)
      err_total++;
    r = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic wr(input logic [11:0] ix, input logic [7:0] v);
    logic [31:0] r;
    apb(1'b1, ix, v, r);
  endtask

  task automatic rd(input logic [11:0] ix, output logic [7:0] v);
    logic [31:0] r;
    apb(1'b0, ix, 8'h00, r);
    v = r[7:0];
  endtask

  task automatic wait_idle();
    logic [7:0] s;
    int n;
    n = 0;
    do begin
      rd(`SMS_IDX_STAT, s);
      n++;
    end while (s[1] !== 1'b0 && n < 200);
    if (n == 200)
      err_total++;
  endtask

  task automatic sl_bit(input logic b);
    tb_mosi <= b;
    repeat (5) @(posedge core_clk);
    tb_sck <= 1'b1;
    repeat (5) @(posedge core_clk);
    tb_sck <= 1'b0;
    repeat (5) @(posedge core_clk);
  endtask

  initial begin
    logic [7:0]  v, d, st;
    logic [31:0] r;
    int          len, rl, pc;
    seed = 20344;
    {psel, penable, pwrite, rerr} = 4'h0;
    paddr = 16'h0000;
    pwdata = 32'h0;
    {rst_n, tb_sck, tb_mosi, m_cpol, m_cpha} = 5'h0;
    tb_sel_n = 1'b1;
    m_tx = 8'h00;
    {err_total, checked, irq_n, cyc} = '0;
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    foreach (rix[k]) begin
      rd(rix[k], v);
      chk("reset value", 0, v);
    end
    apb(1'b0, 12'h123, 8'h00, r);
    chk("unmapped err", 1, rerr);
    chk("unmapped read", 0, r);
    chk("off oe", 0, {mosi_oe, miso_oe});
    for (int i = 0; i < 8; i++) begin
      len = (i == 3) ? 8 : 1 + ($unsigned($random(seed)) % 8);
      rl = (i == 3) ? 4 : 4 + ($unsigned($random(seed)) % 4);
      d = $random(seed);
      m_tx = $random(seed);
      m_cpha = i[1];
      m_cpol = i[2];
      wr(`SMS_IDX_STAT, i[0] ? 8'h70 : 8'hF0);
      wr(`SMS_IDX_BRH, 8'h00);
      wr(`SMS_IDX_BRL, rl[7:0]);
      wr(`SMS_IDX_MODE, {3'b000, len_f(len), 2'b11});
      wr(`SMS_IDX_CTRL, {3'b100, m_cpha, m_cpol, 3'b011});
      wr(`SMS_IDX_MODE, {3'b000, len_f(len), 2'b10});
      pc = irq_n;
      wr(`SMS_IDX_DATA, d);
      if (i == 3)
        wr(`SMS_IDX_DATA, ~d);
      wait_idle();
      chk("half period", rl * 10, 32'(t_last - t_prev));
      chk("idle sck", m_cpol, sck);
      wr(`SMS_IDX_MODE, {3'b000, len_f(len), 2'b11});
      rd(`SMS_IDX_DATA, v);
      chk("rx data", top_f(m_tx, len), v & lo_f(len));
      chk("far rx", top_f(d, len), m_rx & lo_f(len));
      rd(`SMS_IDX_STAT, st);
      chk("status", {1'b1, i == 3, 2'b00}, st[7:4]);
      chk("irq count", 32'(pc + (i % 2 == 0)), irq_n);
    end
    wr(`SMS_IDX_CTRL, 8'h03);
    wr(`SMS_IDX_MODE, 8'h00);
    rd(`SMS_IDX_STAT, st);
    chk("no collision", 0, st[5]);
    tb_sel_n <= 1'b0;
    repeat (4) @(posedge core_clk);
    rd(`SMS_IDX_STAT, st);
    chk("collision", 1, st[5]);
    tb_sel_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    wr(`SMS_IDX_STAT, 8'hF0);
    rd(`SMS_IDX_STAT, st);
    chk("collision clear", 0, st[7:4]);
    wr(`SMS_IDX_CTRL, 8'h80);
    pc = irq_n;
    wr(`SMS_IDX_CTRL, 8'hC0);
    rd(`SMS_IDX_STAT, st);
    chk("force pending", 1, st[7]);
    chk("force irq", pc + 1, irq_n);
    wr(`SMS_IDX_STAT, 8'h80);
    rd(`SMS_IDX_CTRL, v);
    chk("force clear", 8'h80, v);
    wr(`SMS_IDX_BRL, 8'h14);
    wr(`SMS_IDX_CTRL, 8'h20);
    pc = irq_n;
    repeat (200) @(posedge core_clk);
    chk("timer", 1, 32'((irq_n - pc) >= 9 && (irq_n - pc) <= 11));
    rd(`SMS_IDX_STAT, st);
    chk("timer pending", 0, st[7]);
    chk("off oe", 0, {mosi_oe, miso_oe});
    wr(`SMS_IDX_MODE, 8'h01);
    wr(`SMS_IDX_CTRL, 8'h21);
    d = $random(seed);
    wr(`SMS_IDX_DATA, d);
    sl_bit(1'b1);
    sl_bit(1'b0);
    rd(`SMS_IDX_STAT, st);
    chk("ignored clock", 0, {miso_oe, st[1]});
    tb_sel_n <= 1'b0;
    repeat (5) @(posedge core_clk);
    chk("first bit", {1'b1, d[7]}, {miso_oe, miso_drv});
    for (int k = 0; k < 3; k++)
      sl_bit($random(seed));
    tb_sel_n <= 1'b1;
    repeat (5) @(posedge core_clk);
    rd(`SMS_IDX_STAT, st);
    chk("abort", 4'h9, st[7:4]);
    wr(`SMS_IDX_STAT, 8'hF0);
    d = $random(seed);
    m_tx = $random(seed);
    wr(`SMS_IDX_DATA, d);
    tb_sel_n <= 1'b0;
    repeat (5) @(posedge core_clk);
    for (int k = 7; k >= 0; k--) begin
      chk("slave out", d[k], miso_drv);
      sl_bit(m_tx[k]);
    end
    tb_sel_n <= 1'b1;
    repeat (5) @(posedge core_clk);
    rd(`SMS_IDX_DATA, v);
    chk("slave rx", m_tx, v);
    rd(`SMS_IDX_STAT, st);
    chk("slave done", 4'h8, st[7:4]);
    wrap_up();
  end
endmodule // sms_port_tb
`default_nettype wire
